// File: inc/lpcs_if.sv
// bus between the processor end and the clock-gating end
`timescale 1ns/1ps
interface lpcs_if;
  logic [23:0] addr_lines;
  logic        rw_n;
  logic [2:0]  func_code;
  logic        bus_cyc;
  logic        bus_req;
  logic        bus_grant;
  logic        bus_off;
  logic        cpu_clk_en;
  logic        irq_req;
  logic [2:0]  irq_level;
  logic        bus8_sel;
  modport cpu (output addr_lines, rw_n, func_code, bus_cyc, bus_grant,
               bus_off, input bus_req, cpu_clk_en, irq_req, irq_level,
               bus8_sel);
  modport gate (input addr_lines, rw_n, func_code, bus_cyc, bus_grant,
                bus_off, output bus_req, cpu_clk_en, irq_req, irq_level,
                bus8_sel);
endinterface

// File: inc/lpcs_pkg.sv
// package for the low-power clock stop sequence
package lpcs_pkg;
  localparam int          ADDR_W       = 24;
  localparam int          FC_W         = 3;
  localparam logic [2:0]  FC_SUP_DATA  = 3'h5;
  localparam logic [23:0] LP_ADDR_RST  = 24'h000000;
  localparam logic [15:0] SW_RST       = 16'h2700;
  localparam logic [15:0] STOP_IMM_RST = 16'h2000;
  localparam logic [2:0]  MASK_LSB     = 3'h0;
  localparam int          MASK_POS     = 8;
  localparam int          SUP_POS      = 13;
  localparam logic [2:0]  CNT_RST      = 3'h0;
  localparam logic [2:0]  CYC_W16      = 3'h3;
  localparam logic [2:0]  CYC_W8       = 3'h4;
  typedef enum logic [2:0] {
    LPCS_RUN   = 3'b000,
    LPCS_WRITE = 3'b001,
    LPCS_STOP  = 3'b010,
    LPCS_ARB   = 3'b011,
    LPCS_SLEEP = 3'b100,
    LPCS_RTE   = 3'b101
  } lpcs_cpu_st_t;
endpackage

// File: src/lpcs_cpu.sv
// processor end: low-power routine bus sequence with stoppable clock
`timescale 1ns/1ps
// Behaviour
// - low power only entered from supervisor mode
// - enter from an exception routine
// - partner watches address, direction, function code
// - match needs low address write, code 101
// - partner counts cycles from matching write
// - clock stops after immediate operand read
// - 8-bit bus fetches operand in three cycles
// - no runt clock pulses to processor
// - bus arbitration completes during operand fetch
// - routine first writes zero byte to address
// - halt loads status word, sets interrupt mask
// - exception return resumes normal execution
// - state retained while clock stopped
// - data bus width fixed 8 or 16
// - clock may stop indefinitely
module lpcs_cpu
  import lpcs_pkg::*;
#(
  parameter int ADDR_BITS = ADDR_W,
  parameter int FC_BITS   = FC_W,
  parameter int SW_BITS   = 16
)
(
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic                 ce,
  lpcs_if.cpu                       bus,
  input  wire logic                 enter_req,
  input  wire logic [ADDR_W-1:0]    lp_addr,
  input  wire logic [15:0]          stop_imm,
  output logic [15:0]               status_word,
  output logic                      in_low_power,
  output logic                      done,
  output logic                      refused
);
  import lpcs_pkg::*;

  // bus and status word layout are fixed by the sequence
  if (ADDR_BITS != ADDR_W) begin : g_addr_bits_chk
    $error("address width must equal the bus width");
  end
  if (FC_BITS != FC_W) begin : g_fc_bits_chk
    $error("function code width must equal the bus width");
  end
  if (SW_BITS != 16) begin : g_sw_bits_chk
    $error("status word must be 16 bits");
  end
  if (SUP_POS >= SW_BITS || MASK_POS + 3 > SW_BITS) begin : g_sw_pos_chk
    $error("status word fields out of range");
  end
  // partner counts must cover the write and every operand fetch
  if (CYC_W16 != 3'h3 || CYC_W8 != 3'h4) begin : g_count_chk
    $error("partner cycle counts disagree with fetch lengths");
  end
  if (CNT_RST != 3'h0) begin : g_cnt_rst_chk
    $error("fetch count must start from zero");
  end

  lpcs_cpu_st_t st_reg;
  lpcs_cpu_st_t st_next;
  logic [2:0]   fetch_reg;
  logic [2:0]   fetch_next;
  logic [2:0]   fetch_len;
  logic         last_fetch;
  logic         grant_reg;
  logic         gclk;
  logic         sup_mode;
  logic [2:0]   irq_mask;
  logic         irq_wake;
  logic [15:0]  saved_sw_reg;
  logic [15:0]  sw_next;
  logic         sw_load;
  logic [23:0]  wr_addr_reg;

  // state only moves while the partner lets the clock run
  assign gclk       = ce && bus.cpu_clk_en;
  assign fetch_len  = bus.bus8_sel ? 3'h2 : 3'h1;
  assign last_fetch = st_reg == LPCS_STOP && fetch_reg == fetch_len;
  assign sup_mode   = status_word[SUP_POS];
  assign irq_mask   = status_word[MASK_POS +: 3];
  assign irq_wake   = bus.irq_req && bus.irq_level > irq_mask;

  // sequence: write, immediate fetch, arbitration, sleep, return
  always_comb begin
    st_next    = st_reg;
    fetch_next = fetch_reg;
    unique case (st_reg)
      LPCS_RUN: begin
        if (enter_req && sup_mode) begin
          st_next = LPCS_WRITE;
        end
      end
      LPCS_WRITE: begin
        st_next    = LPCS_STOP;
        fetch_next = CNT_RST;
      end
      LPCS_STOP: begin
        if (last_fetch) begin
          st_next = LPCS_ARB;
        end else begin
          fetch_next = fetch_reg + 3'h1;
        end
      end
      LPCS_ARB: begin
        st_next = LPCS_SLEEP;
      end
      LPCS_SLEEP: begin
        if (irq_wake) begin
          st_next = LPCS_RTE;
        end
      end
      LPCS_RTE: begin
        st_next = LPCS_RUN;
      end
      default: begin
        st_next = LPCS_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= LPCS_RUN;
    end else if (gclk) begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fetch_reg <= CNT_RST;
    end else if (gclk) begin
      fetch_reg <= fetch_next;
    end
  end

  // address held for the write even if the input moves
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_addr_reg <= LP_ADDR_RST;
    end else if (gclk && st_reg == LPCS_RUN && st_next == LPCS_WRITE) begin
      wr_addr_reg <= lp_addr;
    end
  end

  // halt operand loads the mask, return restores the saved word
  always_comb begin
    sw_load = 1'b0;
    sw_next = status_word;
    if (last_fetch) begin
      sw_load = 1'b1;
      sw_next = stop_imm;
    end else if (st_reg == LPCS_RTE) begin
      sw_load = 1'b1;
      sw_next = saved_sw_reg;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_word <= SW_RST;
    end else if (gclk && sw_load) begin
      status_word <= sw_next;
    end
  end

  // word in force when the sequence began, put back on return
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      saved_sw_reg <= SW_RST;
    end else if (gclk && st_reg == LPCS_RUN && st_next == LPCS_WRITE) begin
      saved_sw_reg <= status_word;
    end
  end

  // grant follows a request once the sequence has started
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      grant_reg <= 1'b0;
    end else if (gclk) begin
      grant_reg <= bus.bus_req && st_reg != LPCS_RUN;
    end
  end

  // write to the chosen address, then supervisor program fetches
  always_comb begin
    bus.addr_lines = '0;
    bus.rw_n       = 1'b1;
    bus.func_code  = FC_SUP_DATA;
    bus.bus_cyc    = 1'b0;
    if (st_reg == LPCS_WRITE) begin
      bus.addr_lines = wr_addr_reg;
      bus.rw_n       = 1'b0;
      bus.bus_cyc    = 1'b1;
    end else if (st_reg == LPCS_STOP) begin
      bus.func_code = 3'h6;
      bus.bus_cyc   = 1'b1;
    end
  end

  assign bus.bus_grant = grant_reg;
  assign bus.bus_off   = grant_reg && st_reg == LPCS_SLEEP;
  assign in_low_power  = st_reg == LPCS_SLEEP;
  assign done          = st_reg == LPCS_RTE && gclk;
  assign refused       = enter_req && st_reg == LPCS_RUN && !sup_mode;
endmodule // lpcs_cpu

// File: src/lpcs_gate.sv
// clock-gating end: address match, bus cycle count, clock stop
`timescale 1ns/1ps
module lpcs_gate
  import lpcs_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic                 ce,
  lpcs_if.gate                      bus,
  input  wire logic [ADDR_W-1:0]    lp_addr,
  input  wire logic                 bus8_mode,
  input  wire logic                 tristate_req,
  input  wire logic                 irq_in,
  input  wire logic [2:0]           irq_lvl_in,
  output logic                      cpu_clk_en,
  output logic                      sleeping
);
  import lpcs_pkg::*;
  logic       match;
  logic       armed_reg;
  logic [2:0] cnt_reg;
  logic       stop_reg;
  logic [2:0] target;

  assign match = bus.bus_cyc && bus.addr_lines == lp_addr
                 && !bus.rw_n && bus.func_code == FC_SUP_DATA;
  assign target = bus8_mode ? CYC_W8 : CYC_W16;

  // count from the matching write itself
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      armed_reg <= 1'b0;
      cnt_reg   <= CNT_RST;
    end else if (ce) begin
      if (stop_reg && irq_in) begin
        armed_reg <= 1'b0;
        cnt_reg   <= CNT_RST;
      end else if (!armed_reg && match) begin
        armed_reg <= 1'b1;
        cnt_reg   <= 3'h1;
      end else if (armed_reg && bus.bus_cyc && cnt_reg != target) begin
        cnt_reg <= cnt_reg + 3'h1;
      end
    end
  end

  // stop on the edge ending the first idle cycle after the immediate fetch, one full cycle at a time
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) stop_reg <= 1'b0;
    else if (ce) begin
      if (stop_reg && irq_in) stop_reg <= 1'b0;
      else if (armed_reg && cnt_reg == target && !bus.bus_cyc)
        stop_reg <= 1'b1;
    end
  end

  assign bus.bus_req    = tristate_req && armed_reg;
  assign bus.cpu_clk_en = !stop_reg;
  assign bus.irq_req    = irq_in;
  assign bus.irq_level  = irq_lvl_in;
  assign bus.bus8_sel   = bus8_mode;
  assign cpu_clk_en     = !stop_reg;
  assign sleeping       = stop_reg;
endmodule // lpcs_gate

// File: testbench/lpcs_chk.sv
// checker for the low-power bus sequence
`timescale 1ns/1ps
module lpcs_chk (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       rw_n,
  input wire logic [2:0] func_code,
  input wire logic       bus_cyc,
  input wire logic       bus_req,
  input wire logic       bus_grant,
  input wire logic       cpu_clk_en,
  input wire logic       irq_req,
  input wire logic       bus8_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wr_code_a: assert property (bus_cyc && !rw_n |-> func_code == 3'h5)
    else $error("write code");
  fetch_w16_a: assert property (bus_cyc && !rw_n && !bus8_sel
    |=> (bus_cyc && rw_n)[*2] ##1 !bus_cyc) else $error("fetch 16");
  fetch_w8_a: assert property (bus_cyc && !rw_n && bus8_sel
    |=> (bus_cyc && rw_n)[*3] ##1 !bus_cyc) else $error("fetch 8");
  stop_idle_a: assert property ($fell(cpu_clk_en) |-> !bus_cyc)
    else $error("stop busy");
  stop_hold_a: assert property ($fell(cpu_clk_en) |=> !cpu_clk_en)
    else $error("runt");
  sleep_quiet_a: assert property (!cpu_clk_en |-> !bus_cyc)
    else $error("bus asleep");
  grant_req_a: assert property ($rose(bus_grant) |-> $past(bus_req))
    else $error("grant");
  wake_a: assert property (!cpu_clk_en && irq_req |-> ##[1:8] cpu_clk_en)
    else $error("wake");
endmodule // lpcs_chk

// File: testbench/lpcs_tb_top.sv
// testbench: both ends joined, random low-power entries
`timescale 1ns/1ps
module lpcs_tb_top;
  import lpcs_pkg::*;
  logic        clk, arst_n, en, b8, tsr, irq, done, slp, ilp, cke, rfs;
  logic [15:0] imm, sw;
  logic [23:0] la;
  logic [31:0] rs;
  int          fail_count, cmp_count;
  lpcs_if bus ();
  lpcs_cpu lpcs_cpu_inst (.clk(clk), .arst_n(arst_n), .ce(1'b1), .bus(bus),
    .enter_req(en), .lp_addr(la), .stop_imm(imm), .status_word(sw),
    .in_low_power(ilp), .done(done), .refused(rfs));
  lpcs_gate lpcs_gate_inst (.clk(clk), .arst_n(arst_n), .ce(1'b1), .bus(bus),
    .lp_addr(la), .bus8_mode(b8), .tristate_req(tsr), .irq_in(irq),
    .irq_lvl_in(3'h7), .cpu_clk_en(cke), .sleeping(slp));
  lpcs_chk lpcs_chk_inst (.clk(clk), .arst_n(arst_n), .rw_n(bus.rw_n),
    .func_code(bus.func_code), .bus_cyc(bus.bus_cyc), .bus_req(bus.bus_req),
    .bus_grant(bus.bus_grant), .cpu_clk_en(bus.cpu_clk_en),
    .irq_req(bus.irq_req), .bus8_sel(bus.bus8_sel));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // halt operand: supervisor bit kept, mask below level 7
  function automatic logic [15:0] imm_of(input logic [31:0] r);
    return 16'h2000 | {5'h00, 3'(r % 7), 8'h00};
  endfunction
  task automatic chk(input string n, input logic [15:0] s, e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wt(input bit k);
    for (int n = 0; n < 80; n++) begin
      @(posedge clk);
      #1;
      if (k ? done === 1'b1 : cke === 1'b0) return;
    end
    chk("wait", 16'h0000, 16'h0001);
    test_done();
  endtask
  initial begin
    {arst_n, en, b8, tsr, irq} = 5'h00;
    imm = 16'h2000;
    la = 24'h000000;
    rs = 32'hA683;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (i == 2) begin
        @(posedge clk);
        arst_n <= 1'b0;
        b8 <= 1'b1;
        @(posedge clk);
        chk("sw_rst", sw, SW_RST);
        arst_n <= 1'b1;
      end
      rs = xs(rs);
      @(posedge clk);
      la <= rs[31:8];
      imm <= imm_of(rs);
      tsr <= 1'(i & 1);
      en <= 1'b1;
      #1;
      chk("refused", {15'h0000, rfs}, 16'h0000);
      @(posedge clk);
      en <= 1'b0;
      wt(1'b0);
      chk("status", sw, imm_of(rs));
      chk("sleep", {15'h0000, slp & ilp}, 16'h0001);
      chk("tristate", {15'h0000, bus.bus_off}, {15'h0000, tsr});
      @(posedge clk);
      irq <= 1'b1;
      wt(1'b1);
      @(posedge clk);
      irq <= 1'b0;
      #1;
      chk("awake", {15'h0000, cke}, 16'h0001);
      chk("restored", sw, SW_RST);
      $display("test %0d done", i);
    end
    test_done();
  end
endmodule // lpcs_tb_top
